// *** pcx_target.v ***
// target side of the expansion bus core with user-side decode and phase control
`include "pcx_regs.vh"

module pcx_target (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // bus pins, sampled synchronously
   input wire frame_n_i,
   input wire irdy_n_i,
   input wire [31:0] ad_i,
   input wire [3:0] cbe_n_i,
   output reg [31:0] ad_o,
   output reg ad_oe,
   output wire bus_target_ready_line_n_o,
   output wire bus_target_ready_line_oe,
   output wire stop_n_o,
   output wire stop_n_oe,
   output wire bus_device_select_line_n_o,
   output wire bus_device_select_line_oe,
   // user side: claim and transaction info
   output reg [`PCX_NUM_REGIONS-1:0] region_claim,
   output reg transfer_direction_flag,
   output reg data_phase_strobe,
   output reg [3:0] registered_byte_enables,
   output reg [15:0] pci_cmd,
   output reg [31:0] addr_latched,
   output reg addr_valid,
   // user side: shared address/data bus
   input wire [31:0] shared_addr_data_bus_i,
   output reg [31:0] shared_addr_data_bus_o,
   output wire shared_addr_data_bus_oe,
   // user side: target state indications
   output wire st_idle,
   output wire st_busy,
   output wire st_data,
   output wire st_backoff,
   // user side: phase requests
   input wire user_ready,
   input wire user_term,
   input wire user_abort
);

   // one-hot target states
   localparam S_IDLE = 5'b00001;
   localparam S_BUSY = 5'b00010;
   localparam S_DATA = 5'b00100;
   localparam S_BACK = 5'b01000;
   localparam S_TURN = 5'b10000;

   localparam BW = `PCX_BASE_MSB - `PCX_BASE_LSB + 1;

   reg [4:0] state_r; // target state
   reg frame_q_r; // frame one cycle ago, for start detection
   reg [1:0] ctrl_r; // enable and burst permission
   reg [BW-1:0] base_r [0:`PCX_NUM_REGIONS-1]; // region bases
   reg [3:0] cmd_r; // raw command of this transaction
   reg nonlin_r; // non-linear burst order seen
   reg first_r; // still in first data phase
   reg lead0_r, lead_r; // read data: user drives it, then it is registered onto the pins
   reg abort_r; // target abort in progress
   reg ready_q_r; // pipelined user ready request
   reg term_q_r; // pipelined user stop request
   reg abort_q_r; // pipelined user abort request
   reg [7:0] retry_cnt_r; // retries signalled
   reg [7:0] abort_cnt_r; // target aborts signalled
   wire [`PCX_NUM_REGIONS-1:0] hit; // region compare results

   // memory-space command test
   function is_mem;
      input [3:0] c;
      begin
         is_mem = (c == `PCX_CMD_MEM_RD) | (c == `PCX_CMD_MEM_WR) |
            (c == `PCX_CMD_MEM_RD_MUL) | (c == `PCX_CMD_MEM_RD_LINE) |
            (c == `PCX_CMD_MEM_WR_INV);
      end
   endfunction

   // one compare per region
   genvar gi;
   generate
      for (gi = 0; gi < `PCX_NUM_REGIONS; gi = gi + 1) begin : g_region
         pcx_bar_match u_match (
            .base(base_r[gi]),
            .addr(addr_latched),
            .enable(ctrl_r[`PCX_CTRL_EN_BIT]),
            .hit(hit[gi])
         );
      end
   endgenerate

   // effective mode; forced terms override the user pair
   wire in_data = state_r[2];
   wire eff_ready = ready_q_r | nonlin_r;
   wire eff_term = term_q_r | nonlin_r |
      (~ctrl_r[`PCX_CTRL_BURST_BIT] & ready_q_r);
   wire data_ok = transfer_direction_flag | lead_r; // read turnaround
   // requests act only in the data state, never while inactive
   wire drive_trdy = in_data & ~abort_q_r & eff_ready & data_ok;
   // no stop alone while read data settles, else the bus would see a retry
   wire drive_stop = (in_data & ((eff_term & (data_ok | ~eff_ready)) | abort_q_r)) | (state_r[3]);
   wire drive_devsel = (in_data & ~abort_q_r) | (state_r[3] & ~abort_r);
   wire xfer = drive_trdy & ~irdy_n_i; // data phase completes at this edge

   // control pins driven from claim until after turnaround
   wire ctl_oe = state_r[2] | state_r[3] | state_r[4];
   assign bus_target_ready_line_n_o = ~drive_trdy;
   assign bus_target_ready_line_oe = ctl_oe;
   assign stop_n_o = ~drive_stop;
   assign stop_n_oe = ctl_oe;
   assign bus_device_select_line_n_o = ~drive_devsel;
   assign bus_device_select_line_oe = ctl_oe;

   // state indications to the user
   assign st_idle = state_r[0];
   assign st_busy = state_r[1];
   assign st_data = state_r[2];
   assign st_backoff = state_r[3];

   // user owns the shared bus only during read data state
   assign shared_addr_data_bus_oe = ~(in_data & ~transfer_direction_flag);

   // target state machine and transaction capture
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r <= S_IDLE;
         frame_q_r <= 1'b1;
         cmd_r <= 4'h0;
         nonlin_r <= 1'b0;
         first_r <= 1'b0;
         {lead0_r, lead_r} <= 2'b00;
         abort_r <= 1'b0;
         ready_q_r <= 1'b0;
         term_q_r <= 1'b0;
         abort_q_r <= 1'b0;
         retry_cnt_r <= 8'h00;
         abort_cnt_r <= 8'h00;
         region_claim <= {`PCX_NUM_REGIONS{1'b0}};
         transfer_direction_flag <= 1'b0;
         data_phase_strobe <= 1'b0;
         registered_byte_enables <= 4'h0;
         pci_cmd <= 16'h0000;
         addr_latched <= 32'h00000000;
         addr_valid <= 1'b0;
         shared_addr_data_bus_o <= 32'h00000000;
         ad_o <= 32'h00000000;
         ad_oe <= 1'b0;
      end else begin
         // pins and requests pass one register stage
         frame_q_r <= frame_n_i;
         ready_q_r <= user_ready;
         term_q_r <= user_term;
         abort_q_r <= user_abort;
         registered_byte_enables <= ~cbe_n_i;
         shared_addr_data_bus_o <= ad_i;
         ad_o <= shared_addr_data_bus_i;
         region_claim <= {`PCX_NUM_REGIONS{1'b0}};
         data_phase_strobe <= 1'b0;
         addr_valid <= 1'b0;
         lead0_r <= in_data;
         lead_r <= in_data & lead0_r;
         case (state_r)
            S_IDLE: begin
               // falling frame marks the address phase
               if (!frame_n_i && frame_q_r) begin
                  addr_latched <= ad_i;
                  addr_valid <= 1'b1;
                  cmd_r <= cbe_n_i; // command bits travel uninverted
                  pci_cmd <= 16'h0001 << cbe_n_i;
                  nonlin_r <= (ad_i[1:0] != `PCX_BURST_LINEAR);
                  state_r <= S_BUSY;
               end
            end
            S_BUSY: begin
               // medium decode: claim one cycle after the address
               if ((|hit) && is_mem(cmd_r)) begin
                  region_claim <= hit;
                  transfer_direction_flag <= cmd_r[0];
                  first_r <= 1'b1;
                  abort_r <= 1'b0;
                  state_r <= S_DATA;
               end else if (frame_n_i && irdy_n_i) begin
                  state_r <= S_IDLE;
               end
            end
            S_DATA: begin
               if (abort_q_r) begin
                  // fatal error: stop without device select
                  abort_r <= 1'b1;
                  abort_cnt_r <= abort_cnt_r + 8'h01;
                  state_r <= frame_n_i ? S_TURN : S_BACK;
               end else if (xfer) begin
                  data_phase_strobe <= 1'b1;
                  first_r <= 1'b0;
                  {lead0_r, lead_r} <= 2'b00;
                  // initiator last phase wins over our own stop
                  if (frame_n_i)
                     state_r <= S_TURN;
                  else if (eff_term)
                     state_r <= S_BACK;
               end else if (eff_term && !eff_ready) begin
                  // stop with no data: a retry when nothing moved yet
                  if (first_r)
                     retry_cnt_r <= retry_cnt_r + 8'h01;
                  state_r <= frame_n_i ? S_TURN : S_BACK;
               end else if (frame_n_i && irdy_n_i) begin
                  state_r <= S_TURN;
               end
            end
            S_BACK: begin
               // hold stop until the initiator drops frame
               if (frame_n_i)
                  state_r <= S_TURN;
            end
            default: begin
               // turnaround: pins driven inactive one cycle, then released
               abort_r <= 1'b0;
               state_r <= S_IDLE;
            end
         endcase
         // read data leaves on the bus one cycle after the user drives it
         ad_oe <= in_data & ~transfer_direction_flag & ~xfer;
      end
   end

   // apb: zero wait, unmapped offsets answer with an error
   wire mapped = (paddr == `PCX_OFF_CTRL) || (paddr == `PCX_OFF_BASE0) ||
      (paddr == `PCX_OFF_BASE1) || (paddr == `PCX_OFF_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // apb register writes in the access cycle, read data capture in the setup cycle
   integer i;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_r <= `PCX_CTRL_RST;
         for (i = 0; i < `PCX_NUM_REGIONS; i = i + 1)
            base_r[i] <= `PCX_BASE_RST;
         prdata <= 32'h00000000;
      end else begin
         if (psel && penable && pwrite) begin
            if (paddr == `PCX_OFF_CTRL) begin
               ctrl_r <= pwdata[1:0];
            end else if (paddr == `PCX_OFF_BASE0) begin
               base_r[0] <= pwdata[`PCX_BASE_MSB:`PCX_BASE_LSB];
            end else if (paddr == `PCX_OFF_BASE1) begin
               base_r[1] <= pwdata[`PCX_BASE_MSB:`PCX_BASE_LSB];
            end
         end
         if (psel && !penable) begin
            if (paddr == `PCX_OFF_CTRL) begin
               prdata <= {30'h00000000, ctrl_r};
            end else if (paddr == `PCX_OFF_BASE0) begin
               prdata <= {base_r[0], 16'h0000};
            end else if (paddr == `PCX_OFF_BASE1) begin
               prdata <= {base_r[1], 16'h0000};
            end else if (paddr == `PCX_OFF_STATUS) begin
               prdata <= {abort_cnt_r, retry_cnt_r, 11'h000, state_r};
            end else begin
               prdata <= 32'h00000000;
            end
         end
      end
   end

endmodule

// *** pcx_regs.vh ***
// register offsets, field positions, reset values and bus codes for the target core
`ifndef PCX_REGS_VH
`define PCX_REGS_VH

// apb byte offsets
`define PCX_OFF_CTRL 12'h000
`define PCX_OFF_BASE0 12'h004
`define PCX_OFF_BASE1 12'h008
`define PCX_OFF_STATUS 12'h00c

// control register fields
`define PCX_CTRL_EN_BIT 0
`define PCX_CTRL_BURST_BIT 1
`define PCX_CTRL_RST 2'h0

// base register: upper address bits compared, fixed 64 KiB regions
`define PCX_BASE_MSB 31
`define PCX_BASE_LSB 16
`define PCX_BASE_RST 16'h0000

// number of claimable regions
`define PCX_NUM_REGIONS 2

// bus commands accepted as memory space
`define PCX_CMD_MEM_RD 4'h6
`define PCX_CMD_MEM_WR 4'h7
`define PCX_CMD_MEM_RD_MUL 4'hc
`define PCX_CMD_MEM_RD_LINE 4'he
`define PCX_CMD_MEM_WR_INV 4'hf

// linear burst order code in ad[1:0]
`define PCX_BURST_LINEAR 2'h0

`endif

// *** pcx_bar_match.v ***
// address region compare for one claimable base region
`include "pcx_regs.vh"

module pcx_bar_match (
   // compare inputs
   input wire [`PCX_BASE_MSB-`PCX_BASE_LSB:0] base,
   input wire [31:0] addr,
   input wire enable,
   // result
   output wire hit
);

   // upper address bits must equal the programmed base
   assign hit = enable & (addr[`PCX_BASE_MSB:`PCX_BASE_LSB] == base);

endmodule

// *** pcx_user_model.sv ***
// user logic model: region selects, byte-lane store, phase requests
module pcx_user_model (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // transaction info from the core
   input wire [1:0] region_claim,
   input wire transfer_direction_flag,
   input wire data_phase_strobe,
   input wire [3:0] registered_byte_enables,
   input wire st_data,
   input wire [31:0] shared_addr_data_bus_o,
   // requests and read data to the core
   output logic [31:0] shared_addr_data_bus_i,
   output logic user_ready,
   output logic user_term,
   output logic user_abort,
   // bench side: {term, ready} wanted, stored words
   input wire [1:0] mode_req,
   output logic [63:0] store_r
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] rd_sel_r; // read select per region
   logic [1:0] wr_sel_r; // write select per region
   logic [3:0] noise_r; // keeps the idle bus moving
   wire [31:0] rdata = rd_sel_r[1] ? store_r[63:32] : store_r[31:0];
   // all lanes driven, byte enables ignored on reads
   assign shared_addr_data_bus_i = (|rd_sel_r && st_data) ? rdata : {8{noise_r}};
   // selects, requests and store
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         {rd_sel_r, wr_sel_r, noise_r, store_r} <= '0;
         {user_abort, user_term, user_ready} <= 3'h4;
      end else begin
         noise_r <= noise_r + 4'h1;
         // from flops, so mode_req leads the pins by two cycles
         {user_abort, user_term, user_ready} <= {1'h0, mode_req};
         for (int k = 0; k < 2; k++) begin
            // set dominant; whole region mapped, so no holes
            if (region_claim[k])
               {rd_sel_r[k], wr_sel_r[k]} <= {!transfer_direction_flag, transfer_direction_flag};
            else if (!st_data)
               {rd_sel_r[k], wr_sel_r[k]} <= 2'h0;
            for (int b = 0; b < 4; b++)
               if (wr_sel_r[k] && data_phase_strobe && registered_byte_enables[b])
                  store_r[32*k+8*b +: 8] <= shared_addr_data_bus_o[8*b +: 8];
         end
      end
   end
endmodule

// *** pcx_target_sva.sv ***
// port assertions for the target core
`include "pcx_regs.vh"
module pcx_chk (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // inputs to the core
   input wire irdy_n_i,
   input wire user_ready,
   input wire user_term,
   input wire user_abort,
   // core outputs
   input wire [`PCX_NUM_REGIONS-1:0] region_claim,
   input wire transfer_direction_flag,
   input wire data_phase_strobe,
   input wire st_idle,
   input wire st_data,
   input wire [31:0] addr_latched,
   input wire bus_target_ready_line_n_o,
   input wire bus_target_ready_line_oe,
   input wire stop_n_o,
   input wire stop_n_oe,
   input wire bus_device_select_line_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // a request taken at one edge acts in the next data cycle; non-linear order overrides it
   sequence req_then_data(t, r);
      user_term == t && user_ready == r && !user_abort
         ##1 st_data && addr_latched[1:0] == `PCX_BURST_LINEAR;
   endsequence
   claim_pulse_a: assert property (|region_claim |=> region_claim == '0)
      else $error("claim held over one cycle");
   wait_mode_a: assert property (req_then_data(1'h0, 1'h0)
      |-> bus_target_ready_line_n_o && stop_n_o) else $error("wait mode not kept");
   retry_mode_a: assert property (req_then_data(1'h1, 1'h0)
      |-> !stop_n_o && bus_target_ready_line_n_o) else $error("retry not signalled");
   devsel_data_a: assert property (st_data && !$past(user_abort) |-> !bus_device_select_line_n_o)
      else $error("device select missing in data");
   idle_quiet_a: assert property (st_idle ##1 st_idle
      |-> !bus_target_ready_line_oe && !stop_n_oe) else $error("driving while idle");
   strobe_cause_a: assert property (data_phase_strobe
      |-> $past(!bus_target_ready_line_n_o && !irdy_n_i)) else $error("strobe without phase");
   single_strobe_a: assert property (data_phase_strobe |=> !data_phase_strobe)
      else $error("second data phase");
   dir_held_a: assert property (st_data ##1 st_data |-> $stable(transfer_direction_flag))
      else $error("direction changed in transfer");
endmodule
bind pcx_target pcx_chk u_chk (.clk_sys, .nrst, .irdy_n_i, .user_ready, .user_term,
   .user_abort, .region_claim, .transfer_direction_flag, .data_phase_strobe, .st_idle,
   .st_data, .addr_latched, .bus_target_ready_line_n_o, .bus_target_ready_line_oe, .stop_n_o,
   .stop_n_oe,
   .bus_device_select_line_n_o);

// *** pci_target_decode_and_phase_control_bench.sv ***
// bench: apb setup, then bus transfers against the user model
`include "pcx_regs.vh"
module pci_target_decode_and_phase_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic frame_n_i = 1'h1, irdy_n_i = 1'h1, pready, pslverr, ad_oe, ok, slv, drv;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, ad_i = 32'h0, prdata, ad_o, rd;
   logic [31:0] shared_addr_data_bus_i, shared_addr_data_bus_o;
   logic [3:0] cbe_n_i = 4'hf, registered_byte_enables;
   logic [1:0] mode_req = 2'h3, region_claim;
   logic bus_target_ready_line_n_o, bus_target_ready_line_oe, stop_n_o, stop_n_oe;
   logic transfer_direction_flag, data_phase_strobe, st_data, user_ready, user_term, user_abort;
   logic [63:0] store_r;
   int err_count = 0, n_checks = 0, cyc = 0, lat;
   pcx_target u_dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .frame_n_i, .irdy_n_i, .ad_i, .cbe_n_i, .ad_o, .ad_oe,
      .bus_target_ready_line_n_o, .bus_target_ready_line_oe, .stop_n_o, .stop_n_oe,
      .bus_device_select_line_n_o(), .bus_device_select_line_oe(), .region_claim,
      .transfer_direction_flag, .data_phase_strobe, .registered_byte_enables, .pci_cmd(),
      .addr_latched(), .addr_valid(), .shared_addr_data_bus_i, .shared_addr_data_bus_o,
      .shared_addr_data_bus_oe(), .st_idle(), .st_busy(), .st_data, .st_backoff(),
      .user_ready, .user_term, .user_abort);
   pcx_user_model u_user (.clk_sys, .nrst, .region_claim, .transfer_direction_flag,
      .data_phase_strobe, .registered_byte_enables, .st_data, .shared_addr_data_bus_o,
      .shared_addr_data_bus_i, .user_ready, .user_term, .user_abort, .mode_req, .store_r);
   initial forever #12.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // apb: setup, access held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge clk_sys);
      penable <= 1'h1;
      do @(posedge clk_sys); while (pready !== 1'h1);
      {rd, slv} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
   endtask
   // one-phase initiator transfer; odd commands write
   task automatic pci_tx(input logic [3:0] cmd, input logic [31:0] a, d, input logic [3:0] be);
      @(posedge clk_sys);
      {frame_n_i, ad_i, cbe_n_i} <= {1'h0, a, cmd};
      @(posedge clk_sys);
      {frame_n_i, irdy_n_i, ad_i, cbe_n_i} <= {2'h2, cmd[0] ? d : ~a, ~be};
      for (lat = 0; lat < 20; lat++) begin
         @(posedge clk_sys);
         if (bus_target_ready_line_oe === 1'h1 && !(bus_target_ready_line_n_o && stop_n_o))
            break;
      end
      {ok, drv, rd} = {bus_target_ready_line_n_o === 1'h0, ad_oe, ad_o};
      {irdy_n_i, ad_i} <= {1'h1, 32'h0};
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic t_regs;
      apb(1'h0, `PCX_OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, 12'h010, 32'h0);
      chk(slv, 1'h1);
      apb(1'h1, `PCX_OFF_BASE0, 32'h1000_0000);
      apb(1'h1, `PCX_OFF_BASE1, 32'h2000_0000);
      apb(1'h1, `PCX_OFF_CTRL, 32'h1);
      apb(1'h0, `PCX_OFF_BASE1, 32'h0);
      chk(rd, 32'h2000_0000);
   endtask
   task automatic t_write;
      pci_tx(`PCX_CMD_MEM_WR, 32'h1000_0040, 32'ha5a5_5a5a, 4'h5);
      chk(store_r[31:0], 32'h00a5_005a);
      mode_req <= 2'h1;
      pci_tx(`PCX_CMD_MEM_WR_INV, 32'h2000_0080, 32'h1234_5678, 4'hf);
      chk(store_r[63:32], 32'h1234_5678);
   endtask
   task automatic t_read;
      logic [3:0] cmds [3] = '{`PCX_CMD_MEM_RD, `PCX_CMD_MEM_RD_MUL, `PCX_CMD_MEM_RD_LINE};
      for (int i = 0; i < 3; i++) begin
         pci_tx(cmds[i], i[0] ? 32'h2000_0010 : 32'h1000_0010, 32'h0, 4'h1);
         chk(rd, i[0] ? 32'h1234_5678 : 32'h00a5_005a);
         chk(drv, 1'h1);
      end
   endtask
   task automatic t_retry;
      mode_req <= 2'h2;
      pci_tx(`PCX_CMD_MEM_WR, 32'h1000_0000, 32'hffff_ffff, 4'hf);
      chk(ok, 1'h0);
      chk(store_r[31:0], 32'h00a5_005a);
      apb(1'h0, `PCX_OFF_STATUS, 32'h0);
      chk(rd[23:16], 8'h01);
      // same retry request, but a non-linear order forces disconnect with data
      pci_tx(`PCX_CMD_MEM_WR, 32'h1000_0002, 32'h0bad_f00d, 4'hf);
      chk(ok, 1'h1);
      chk(store_r[31:0], 32'h0bad_f00d);
   endtask
   // wait first, then disconnect with data well inside the latency bound
   task automatic t_wait;
      mode_req <= 2'h0;
      fork
         pci_tx(`PCX_CMD_MEM_WR, 32'h2000_0000, 32'hcafe_0001, 4'hf);
         begin
            repeat (6) @(posedge clk_sys);
            mode_req <= 2'h3;
         end
      join
      chk(lat + 2 <= 16, 1'h1);
      chk(store_r[63:32], 32'hcafe_0001);
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      nrst <= 1'h1;
      t_regs();
      t_write();
      t_read();
      t_retry();
      t_wait();
      report_and_stop();
   end
   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         report_and_stop();
      end
   end
endmodule
